/* File: rtl/fsb_defs.svh */
// Constants for the frame session buffering block.
`ifndef FSB_DEFS_SVH
`define FSB_DEFS_SVH

// Core clock rate and the microsecond timebase derived from it.
`define FSB_CLK_HZ        20000000
`define FSB_US_PER_S      1000000
`define FSB_CYC_PER_US    (`FSB_CLK_HZ / `FSB_US_PER_S)
`define FSB_US_DIV_LAST   5'((`FSB_CYC_PER_US) - 1)

// Timing defaults in microseconds: cyclic period 2.0 ms, minimum interval 2.5 ms.
`define FSB_PERIOD_US     16'd2000
`define FSB_MIN_GAP_US    16'd2500

// Sizes.
`define FSB_SLOTS         2
`define FSB_QDEPTH        3'd4
`define FSB_MAX_LEN       4'h8

// Register byte offsets.
`define FSB_REG_CTRL      8'h00
`define FSB_REG_TSTAMP    8'h04
`define FSB_REG_STAT      8'h08
`define FSB_REG_PUSH      8'h0c
`define FSB_SLOT_BASE     8'h10
`define FSB_SLOT_STRIDE   8'h10
`define FSB_SLOT_CFG      8'h00
`define FSB_SLOT_TIMING   8'h04
`define FSB_SLOT_LO       8'h08
`define FSB_SLOT_HI       8'h0c

// Field positions.
`define FSB_CTRL_AUTO     0
`define FSB_CTRL_START    1
`define FSB_CTRL_OPEN_LO  2
`define FSB_CFG_LATEST    0
`define FSB_CFG_CYCLIC    1
`define FSB_CFG_LEN_LO    4
`define FSB_CFG_ID_LO     8
`define FSB_PUSH_LEN_LO   4

`endif

/* File: rtl/fsb_pkg.sv */
// Types shared by the frame session buffering block.
`default_nettype none
package fsb_pkg;

  // Transmit sequencer: one frame on the wire at a time.
  typedef enum logic [1:0] {
    FSB_TX_IDLE  = 2'b00,
    FSB_TX_OFFER = 2'b01,
    FSB_TX_WAIT  = 2'b10
  } fsb_tx_st_t;

  // One received entry: channel, identifier, length, payload, timestamp.
  typedef struct packed {
    logic        chan;
    logic [10:0] id;
    logic [3:0]  len;
    logic [63:0] data;
    logic [31:0] tstamp;
  } fsb_entry_t;

  // Whole state of the block.
  typedef struct packed {
    fsb_tx_st_t             txs;
    logic                   tx_slot;
    logic [10:0]            tx_id;
    logic [3:0]             tx_len;
    logic [63:0]            tx_data;
    logic [4:0]             us_div;
    logic [31:0]            tstamp;
    logic                   auto_start;
    logic [1:0]             open_mask;
    logic [31:0]            rdata;
    logic [1:0]             latest;
    logic [1:0]             cyclic;
    logic [1:0][3:0]        cfg_len;
    logic [1:0][10:0]       cfg_id;
    logic [1:0][15:0]       period;
    logic [1:0][15:0]       gap;
    logic [1:0][31:0]       stage_lo;
    logic [1:0][31:0]       stage_hi;
    logic [1:0]             active;
    logic [1:0][3:0][63:0]  qd;
    logic [1:0][3:0][3:0]   ql;
    logic [1:0][1:0]        rdp;
    logic [1:0][2:0]        cnt;
    logic [1:0][63:0]       cur_data;
    logic [1:0][3:0]        cur_len;
    logic [1:0]             has_cur;
    logic [1:0]             fresh;
    logic [1:0]             due;
    logic [1:0][15:0]       ptimer;
    logic [1:0][15:0]       gtimer;
    logic [1:0]             flushed;
    fsb_entry_t [1:0]       ent;
    logic [1:0]             bcnt;
    logic [1:0]             served;
  } fsb_state_t;

endpackage
`default_nettype wire

/* File: rtl/fsb_core.sv */
// Frame session buffering: all-traffic receive streams and timed transmit slots.
`default_nettype none
`include "fsb_defs.svh"

module fsb_core (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic        rx_chan,
  input  wire logic [10:0] rx_id,
  input  wire logic [3:0]  rx_len,
  input  wire logic [63:0] rx_data,
  output logic      [1:0]  st_valid,
  input  wire logic [1:0]  st_ready,
  output logic             st_chan,
  output logic      [10:0] st_id,
  output logic      [3:0]  st_len,
  output logic      [63:0] st_data,
  output logic      [31:0] st_tstamp,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [10:0] tx_id,
  output logic      [3:0]  tx_len,
  output logic      [63:0] tx_data,
  input  wire logic        tx_ack
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset state.

  // Builds the constant that the state takes under reset.
  function automatic fsb_pkg::fsb_state_t fsb_rst();
    fsb_pkg::fsb_state_t s;
    s            = '0;
    s.txs        = fsb_pkg::FSB_TX_IDLE;
    s.auto_start = 1'b1;
    for (int i = 0; i < `FSB_SLOTS; i++) begin
      s.cfg_len[i] = `FSB_MAX_LEN;
      s.period[i]  = `FSB_PERIOD_US;
      s.gap[i]     = `FSB_MIN_GAP_US;
    end
    return s;
  endfunction

  localparam fsb_pkg::fsb_state_t FSB_RST = fsb_rst();

  fsb_pkg::fsb_state_t state_reg;   // Registered state.
  fsb_pkg::fsb_state_t state_next;  // Next state.
  logic [1:0]          st_take;     // Stream handshakes this cycle.
  logic [1:0]          st_left;     // Open streams still owed the head.

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Each open stream sees the head entry until it takes it.
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_stream
      assign st_valid[k] = (state_reg.bcnt != 2'd0) && state_reg.open_mask[k]
                           && !state_reg.served[k];
      assign st_take[k]  = st_valid[k] && st_ready[k];
      assign st_left[k]  = st_valid[k] && !st_ready[k];
    end
  endgenerate

  // The two-entry buffer refuses a third frame; the link must hold it.
  assign rx_ready  = (state_reg.bcnt != 2'd2);
  assign st_chan   = state_reg.ent[0].chan;
  assign st_id     = state_reg.ent[0].id;
  assign st_len    = state_reg.ent[0].len;
  assign st_data   = state_reg.ent[0].data;
  assign st_tstamp = state_reg.ent[0].tstamp;
  assign tx_valid  = (state_reg.txs == fsb_pkg::FSB_TX_OFFER);
  assign tx_id     = state_reg.tx_id;
  assign tx_len    = state_reg.tx_len;
  assign tx_data   = state_reg.tx_data;
  assign reg_rdata = state_reg.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // All behaviour is computed here from the registered state.
  always_comb begin
    logic                tick;
    logic                psel;
    logic [3:0]          plen;
    logic [63:0]         pdat;
    logic [7:0]          sb;
    logic [1:0]          wp;
    logic [1:0]          hit;
    logic                found;
    logic [1:0]          elig;
    fsb_pkg::fsb_entry_t e;
    tick       = (state_reg.us_div == `FSB_US_DIV_LAST);
    psel       = reg_wdata[0];
    plen       = reg_wdata[`FSB_PUSH_LEN_LO +: 4];
    pdat       = '0;
    sb         = '0;
    wp         = '0;
    hit        = '0;
    found      = 1'b0;
    elig       = '0;
    e          = '0;
    state_next = state_reg;
    state_next.rdata = '0;

    // Microsecond timebase for stamps and timers.
    if (tick) begin
      state_next.us_div = '0;
      state_next.tstamp = state_reg.tstamp + 32'h1;
    end else begin
      state_next.us_div = state_reg.us_div + 5'h1;
    end

    // Global register writes.
    if (reg_wr && reg_addr == `FSB_REG_CTRL) begin
      state_next.auto_start = reg_wdata[`FSB_CTRL_AUTO];
      state_next.open_mask  = reg_wdata[`FSB_CTRL_OPEN_LO +: 2];
    end

    // Per-slot configuration, staging, timers.
    for (int s = 0; s < `FSB_SLOTS; s++) begin
      sb = `FSB_SLOT_BASE + 8'(s * `FSB_SLOT_STRIDE);
      if (reg_wr && reg_addr == sb + `FSB_SLOT_CFG) begin
        state_next.latest[s]  = reg_wdata[`FSB_CFG_LATEST];
        state_next.cyclic[s]  = reg_wdata[`FSB_CFG_CYCLIC];
        state_next.cfg_len[s] = reg_wdata[`FSB_CFG_LEN_LO +: 4];
        state_next.cfg_id[s]  = reg_wdata[`FSB_CFG_ID_LO +: 11];
      end
      if (reg_wr && reg_addr == sb + `FSB_SLOT_TIMING) begin
        state_next.period[s] = reg_wdata[15:0];
        state_next.gap[s]    = reg_wdata[31:16];
      end
      if (reg_wr && reg_addr == sb + `FSB_SLOT_LO) begin
        state_next.stage_lo[s] = reg_wdata;
      end
      if (reg_wr && reg_addr == sb + `FSB_SLOT_HI) begin
        state_next.stage_hi[s] = reg_wdata;
      end
      // A manual start arms every slot that already holds a value.
      if (reg_wr && reg_addr == `FSB_REG_CTRL && reg_wdata[`FSB_CTRL_START]
          && !state_reg.active[s] && (state_reg.has_cur[s] || state_reg.cnt[s] != 3'd0)) begin
        state_next.active[s] = 1'b1;
        state_next.due[s]    = 1'b1;
        state_next.ptimer[s] = state_reg.period[s];
      end
      // Timers advance once per microsecond while the slot runs.
      if (tick && state_reg.active[s]) begin
        if (state_reg.cyclic[s]) begin
          if (state_reg.ptimer[s] <= 16'h1) begin
            state_next.due[s]    = 1'b1;
            state_next.ptimer[s] = state_reg.period[s];
          end else begin
            state_next.ptimer[s] = state_reg.ptimer[s] - 16'h1;
          end
        end
        if (state_reg.gtimer[s] != 16'h0) begin
          state_next.gtimer[s] = state_reg.gtimer[s] - 16'h1;
        end
      end
      // Eligibility: cyclic on its boundary, event only with a fresh value
      // and the gap spent.
      if (state_reg.active[s]) begin
        if (state_reg.cyclic[s]) begin
          elig[s] = state_reg.due[s] && (state_reg.has_cur[s] || state_reg.cnt[s] != 3'd0);
        end else begin
          elig[s] = (state_reg.gtimer[s] == 16'h0) && (state_reg.latest[s] ?
                    state_reg.fresh[s] : state_reg.cnt[s] != 3'd0);
        end
      end
    end

    // Writing ones to the status word clears the matching sticky flush flags.
    if (reg_wr && reg_addr == `FSB_REG_STAT) begin
      state_next.flushed = state_reg.flushed & ~reg_wdata[1:0];
    end

    // Commit of a staged value; only payload and length are used.
    if (reg_wr && reg_addr == `FSB_REG_PUSH) begin
      pdat = {state_reg.stage_hi[psel], state_reg.stage_lo[psel]};
      hit[psel] = 1'b1;
      if (plen > state_reg.cfg_len[psel]) begin
        // Oversize: empty the slot so that nothing goes out.
        state_next.cnt[psel]     = 3'd0;
        state_next.rdp[psel]     = 2'd0;
        state_next.has_cur[psel] = 1'b0;
        state_next.fresh[psel]   = 1'b0;
        state_next.due[psel]     = 1'b0;
        state_next.flushed[psel] = 1'b1;
      end else begin
        if (state_reg.latest[psel]) begin
          // One buffer only: the newest write replaces the older.
          state_next.cur_data[psel] = pdat;
          state_next.cur_len[psel]  = plen;
          state_next.has_cur[psel]  = 1'b1;
          state_next.fresh[psel]    = 1'b1;
        end else if (state_reg.cnt[psel] != `FSB_QDEPTH) begin
          // A full queue refuses the push; status shows it full.
          wp = state_reg.rdp[psel] + state_reg.cnt[psel][1:0];
          state_next.qd[psel][wp] = pdat;
          state_next.ql[psel][wp] = plen;
          state_next.cnt[psel]    = state_reg.cnt[psel] + 3'd1;
        end
        if (state_reg.auto_start && !state_reg.active[psel]) begin
          state_next.active[psel] = 1'b1;
          state_next.due[psel]    = 1'b1;
          state_next.ptimer[psel] = state_reg.period[psel];
        end
      end
    end

    // Transmit sequencer.
    unique case (state_reg.txs)
      fsb_pkg::FSB_TX_IDLE: begin
        // Lowest slot wins, the others wait; a slot flushed now sends nothing.
        for (int s = 0; s < `FSB_SLOTS; s++) begin
          if (elig[s] && !found && !(hit[s] && plen > state_reg.cfg_len[s])) begin
            found = 1'b1;
            state_next.tx_slot = 1'(s);
            state_next.tx_id   = state_reg.cfg_id[s];
            state_next.due[s]  = 1'b0;
            state_next.txs     = fsb_pkg::FSB_TX_OFFER;
            if (!state_reg.latest[s] && state_reg.cnt[s] != 3'd0) begin
              // Pop the oldest value and keep it for repeats.
              state_next.tx_data     = state_reg.qd[s][state_reg.rdp[s]];
              state_next.tx_len      = state_reg.ql[s][state_reg.rdp[s]];
              state_next.cur_data[s] = state_reg.qd[s][state_reg.rdp[s]];
              state_next.cur_len[s]  = state_reg.ql[s][state_reg.rdp[s]];
              state_next.has_cur[s]  = 1'b1;
              state_next.rdp[s]      = state_reg.rdp[s] + 2'd1;
              state_next.cnt[s]      = state_next.cnt[s] - 3'd1;
            end else begin
              // Repeat of the last value, or the newest latest-value write.
              state_next.tx_data  = state_reg.cur_data[s];
              state_next.tx_len   = state_reg.cur_len[s];
              state_next.fresh[s] = hit[s];  // A push now stays pending.
            end
          end
        end
      end
      fsb_pkg::FSB_TX_OFFER: begin
        if (tx_ready) begin
          state_next.txs = fsb_pkg::FSB_TX_WAIT;
        end
      end
      fsb_pkg::FSB_TX_WAIT: begin
        // Gap timing starts at the acknowledge, not at the offer.
        if (tx_ack) begin
          state_next.txs = fsb_pkg::FSB_TX_IDLE;
          if (!state_reg.cyclic[state_reg.tx_slot]) begin
            state_next.gtimer[state_reg.tx_slot] = state_reg.gap[state_reg.tx_slot];
          end
        end
      end
      default: begin
        state_next.txs = fsb_pkg::FSB_TX_IDLE;
      end
    endcase

    // Receive buffer: the head leaves once every open stream has it.
    state_next.served = state_reg.served | st_take;
    if (state_reg.bcnt != 2'd0 && st_left == 2'b00) begin
      state_next.ent[0] = state_reg.ent[1];
      state_next.served = '0;
      state_next.bcnt   = state_reg.bcnt - 2'd1;
    end
    if (rx_valid && rx_ready) begin
      // Stamp at end of frame; channel kept so both copies stay apart.
      e.chan   = rx_chan;
      e.id     = rx_id;
      e.len    = rx_len;
      e.data   = rx_data;
      e.tstamp = state_reg.tstamp;
      state_next.ent[state_next.bcnt[0]] = e;
      state_next.bcnt = state_next.bcnt + 2'd1;
    end

    // Register reads answer in the following cycle only.
    if (reg_rd) begin
      unique case (reg_addr)
        `FSB_REG_CTRL:   state_next.rdata = {29'h0, state_reg.open_mask, state_reg.auto_start};
        `FSB_REG_TSTAMP: state_next.rdata = state_reg.tstamp;
        `FSB_REG_STAT:   state_next.rdata = {28'h0, state_reg.txs, state_reg.flushed};
        default: begin
          for (int s = 0; s < `FSB_SLOTS; s++) begin
            sb = `FSB_SLOT_BASE + 8'(s * `FSB_SLOT_STRIDE);
            if (reg_addr == sb + `FSB_SLOT_CFG) begin
              state_next.rdata = {13'h0, state_reg.cfg_id[s], state_reg.cfg_len[s],
                                  2'h0, state_reg.cyclic[s], state_reg.latest[s]};
            end else if (reg_addr == sb + `FSB_SLOT_TIMING) begin
              state_next.rdata = {state_reg.gap[s], state_reg.period[s]};
            end else if (reg_addr == sb + `FSB_SLOT_LO) begin
              state_next.rdata = {24'h0, state_reg.flushed[s], state_reg.has_cur[s],
                                  state_reg.active[s], 2'h0, state_reg.cnt[s]};
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous reset; the enable freezes everything while low.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= FSB_RST;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

/* File: tb/fsb_core_props.sv */
// Port-level checks for the frame session buffering core.
`default_nettype none
`include "fsb_defs.svh"
module fsb_core_props (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_ready,
  input wire logic [1:0]  st_valid,
  input wire logic [1:0]  st_ready,
  input wire logic [10:0] st_id,
  input wire logic [31:0] st_tstamp,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0]  tx_len,
  input wire logic [63:0] tx_data,
  input wire logic        tx_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////
  logic in_flight_reg;  // High from a taken offer until its acknowledge.
  // Tracks the frame on the wire, because a second offer then would collide.
  always_ff @(posedge core_clk) begin
    if (!resetn) in_flight_reg <= 1'b0;
    else if (tx_valid && tx_ready) in_flight_reg <= 1'b1;
    else if (tx_ack) in_flight_reg <= 1'b0;
  end
  sequence s_offer_held;  // Offer waiting on the link.
    tx_valid && !tx_ready;
  endsequence
  sequence s_take_zero;  // Stream 0 takes the head entry.
    st_valid[0] && st_ready[0];
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data present outside its slot");
  a_offer_held: assert property (s_offer_held |=> tx_valid && $stable(tx_id)
    && $stable(tx_len) && $stable(tx_data)) else $error("offer dropped or changed");
  a_single_flight: assert property (in_flight_reg |-> !tx_valid)
    else $error("second frame offered before acknowledge");
  a_len_bound: assert property (tx_valid |-> tx_len <= `FSB_MAX_LEN)
    else $error("oversize frame offered");
  a_entry_held: assert property (st_valid[0] && !st_ready[0] |=> st_valid[0]
    && $stable(st_id) && $stable(st_tstamp)) else $error("stream entry lost");
  a_empty_ready: assert property (st_valid == 2'b00 |-> rx_ready)
    else $error("receive refused with empty buffer");
  a_shared_head: assert property (s_take_zero ##0 (st_valid[1] && !st_ready[1])
    |=> !st_valid[0]) else $error("head left before every stream took it");
  a_payload_kept: assert property (!tx_valid ##1 !tx_valid |-> $stable(tx_data)
    && $stable(tx_id)) else $error("frame fields moved between offers");
  a_stamp_order: assert property (st_valid != 2'b00 ##1 st_valid != 2'b00
    |-> st_tstamp >= $past(st_tstamp)) else $error("timestamps out of order");
endmodule
bind fsb_core fsb_core_props i_fsb_core_props (.core_clk(core_clk), .resetn(resetn),
  .clk_en(clk_en), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_ready(rx_ready),
  .st_valid(st_valid), .st_ready(st_ready), .st_id(st_id), .st_tstamp(st_tstamp),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_len(tx_len),
  .tx_data(tx_data), .tx_ack(tx_ack));
`default_nettype wire

/* File: tb/fsb_node.sv */
// Model of the other bus nodes: frames in, offers taken and acknowledged.
`default_nettype none
module fsb_node (
  input  wire logic        core_clk,
  input  wire logic [3:0]  stall,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             rx_chan,
  output logic      [10:0] rx_id,
  output logic      [3:0]  rx_len,
  output logic      [63:0] rx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [10:0] tx_id,
  input  wire logic [3:0]  tx_len,
  input  wire logic [63:0] tx_data,
  output logic             tx_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [78:0] sent [$];   // Frames on the wire: id, length, bytes sent.
  int          at [$];     // Cycle at which each offer was taken.
  int          ack_at [$]; // Cycle at which each acknowledge was raised.
  int          cyc = 0;    // Free cycle count.
  int          wait_n = 0; // Cycles an offer has waited.
  int          ack_n = -1; // Countdown to the acknowledge, idle when negative.
  initial begin
    {rx_valid, rx_chan, rx_id, rx_len, rx_data, tx_ready, tx_ack} = '0;
  end
  // Takes offers after a chosen stall and acknowledges a few cycles later.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    tx_ack <= 1'b0;
    if (tx_valid && tx_ready) begin
      // Bytes past the length never reach the wire, so they are not logged.
      sent.push_back({tx_id, tx_len, tx_data & ~(64'hffffffffffffffff << (8 * tx_len))});
      at.push_back(cyc);
      tx_ready <= 1'b0;
      ack_n <= 5;
    end else if (tx_valid && ack_n < 0) begin
      tx_ready <= (wait_n >= stall);
      wait_n <= wait_n + 1;
    end
    if (!tx_valid) wait_n <= 0;
    if (ack_n == 0) begin
      tx_ack <= 1'b1;
      ack_at.push_back(cyc);
    end
    if (ack_n >= 0) ack_n <= ack_n - 1;
  end
  // Hands one received frame over; released lines show inverted values.
  task automatic send(input logic ch, input logic [10:0] id, input logic [63:0] d);
    {rx_valid, rx_chan, rx_id, rx_len, rx_data} <= {1'b1, ch, id, 4'h8, d};
    do @(posedge core_clk); while (!rx_ready);
    {rx_valid, rx_chan, rx_id, rx_len, rx_data} <= {1'b0, ~ch, ~id, 4'h7, ~d};
  endtask
endmodule
`default_nettype wire

/* File: tb/frame_session_buffering_test.sv */
// Self-checking bench for the frame session buffering core.
`default_nettype none
`include "fsb_defs.svh"
module frame_session_buffering_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;  // 20 MHz clock.
  logic        resetn = 1'b0;    // Synchronous reset, active low.
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, st_tstamp;
  logic [1:0]  st_ready = 2'b00, st_valid;
  logic [3:0]  stall = 4'h0, rx_len, st_len, tx_len;
  logic [10:0] rx_id, st_id, tx_id;
  logic [63:0] rx_data, st_data, tx_data;
  logic        rx_valid, rx_ready, rx_chan, st_chan, tx_valid, tx_ready, tx_ack;
  int          err_count = 0;
  int          total_checks = 0;
  always #25 core_clk = ~core_clk;
  fsb_core i_fsb_core (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_chan(rx_chan),
    .rx_id(rx_id), .rx_len(rx_len), .rx_data(rx_data), .st_valid(st_valid),
    .st_ready(st_ready), .st_chan(st_chan), .st_id(st_id), .st_len(st_len),
    .st_data(st_data), .st_tstamp(st_tstamp), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_id(tx_id), .tx_len(tx_len), .tx_data(tx_data), .tx_ack(tx_ack));
  fsb_node i_fsb_node (.core_clk(core_clk), .stall(stall), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_chan(rx_chan), .rx_id(rx_id), .rx_len(rx_len),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
    .tx_len(tx_len), .tx_data(tx_data), .tx_ack(tx_ack));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [78:0] got, input logic [78:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected wire image: only the first n payload bytes travel.
  function automatic logic [78:0] fr(input logic [10:0] id, input logic [3:0] n,
                                     input logic [63:0] d);
    return {id, n, d & ~(64'hffffffffffffffff << (8 * n))};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(reg_rdata, exp);
  endtask
  task automatic cfg(input logic s, input logic [31:0] c, input logic [31:0] t);
    wr(`FSB_SLOT_BASE + `FSB_SLOT_STRIDE * s, c);
    wr(`FSB_SLOT_BASE + `FSB_SLOT_STRIDE * s + `FSB_SLOT_TIMING, t);
  endtask
  // Stages both payload halves, then queues them with the given length.
  task automatic push(input logic s, input logic [3:0] n, input logic [63:0] d);
    wr(`FSB_SLOT_BASE + `FSB_SLOT_STRIDE * s + `FSB_SLOT_LO, d[31:0]);
    wr(`FSB_SLOT_BASE + `FSB_SLOT_STRIDE * s + `FSB_SLOT_HI, d[63:32]);
    wr(`FSB_REG_PUSH, {24'h0, n, 3'h0, s});
  endtask
  task automatic pop(input int k, input logic [11:0] e, output logic [31:0] ts);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (st_valid[k] !== 1'b1 && n < 200);
    check({st_valid[k], st_chan, st_id, st_len, st_data[31:0]}, {1'b1, e, 4'h8, 21'h0, e[10:0]});
    ts = st_tstamp;
    @(posedge core_clk);
    st_ready[k] <= 1'b1;
    @(posedge core_clk);
    st_ready[k] <= 1'b0;
  endtask
  task automatic restart();
    resetn <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    i_fsb_node.sent.delete();
    i_fsb_node.at.delete();
    i_fsb_node.ack_at.delete();
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc(`FSB_REG_CTRL, 32'h1);
    rdc(`FSB_SLOT_BASE, 32'h80);
    rdc(`FSB_SLOT_BASE + `FSB_SLOT_TIMING, 32'h09c407d0);
    rdc(8'hfc, 32'h0);
  endtask
  // Two open streams, both channels, and a third frame held back while full.
  task automatic t_rx();
    logic [31:0] t0, t1;
    wr(`FSB_REG_CTRL, 32'hd);
    i_fsb_node.send(1'b0, 11'h00c, 64'h00c);
    repeat (39) @(posedge core_clk);
    i_fsb_node.send(1'b1, 11'h00c, 64'h00c);
    @(posedge core_clk);
    fork
      i_fsb_node.send(1'b0, 11'h00e, 64'h00e);
    join_none
    @(negedge core_clk);
    check(rx_ready, 1'b0);
    pop(0, 12'h00c, t0);
    pop(1, 12'h00c, t1);
    pop(0, 12'h80c, t1);
    check(t1 - t0, 32'h2);
    pop(1, 12'h80c, t1);
    pop(0, 12'h00e, t1);
    pop(1, 12'h00e, t1);
  endtask
  task automatic t_cyc();
    logic [63:0] v [6];
    v = '{64'h0201, 64'h0403, 64'h0605, 64'h0605, 64'h0605, 64'h0807};
    restart();
    cfg(1'b0, 32'hc22, 32'h30003);
    repeat (10) @(posedge core_clk);  // First push on a microsecond tick.
    push(1'b0, 4'h2, 64'hdead000000000201);
    push(1'b0, 4'h2, 64'h0403);
    push(1'b0, 4'h2, 64'h0605);
    repeat (250) @(posedge core_clk);
    push(1'b0, 4'h2, 64'h0807);
    repeat (70) @(posedge core_clk);
    check(i_fsb_node.sent.size(), 32'h6);
    for (int i = 0; i < 6; i++) begin
      check(i_fsb_node.sent[i], fr(11'h00c, 4'h2, v[i]));
      if (i > 0) check(i_fsb_node.at[i] - i_fsb_node.at[i - 1], 32'h3c);
    end
  endtask
  task automatic t_evt();
    int d;
    restart();
    stall <= 4'h3;
    cfg(1'b1, 32'he80, 32'h30003);
    push(1'b1, 4'h3, 64'hffffffffff060504);
    push(1'b1, 4'h8, 64'h0807060504030201);
    repeat (200) @(posedge core_clk);
    check(i_fsb_node.sent.size(), 32'h2);
    check(i_fsb_node.sent[0], fr(11'h00e, 4'h3, 64'h060504));
    check(i_fsb_node.sent[1], fr(11'h00e, 4'h8, 64'h0807060504030201));
    d = i_fsb_node.at[1] - i_fsb_node.ack_at[0];
    check(d > 40 && d <= 70, 1'b1);
    stall <= 4'h0;
  endtask
  task automatic t_flush();
    restart();
    cfg(1'b0, 32'hc20, 32'h30003);
    push(1'b0, 4'h3, 64'h030201);
    repeat (100) @(posedge core_clk);
    check(i_fsb_node.sent.size(), 32'h0);
    rdc(`FSB_REG_STAT, 32'h1);
    wr(`FSB_REG_STAT, 32'h1);
    rdc(`FSB_REG_STAT, 32'h0);
  endtask
  // Latest-value slots: an event slot overwritten in its gap, a cyclic one repeating.
  task automatic t_latest();
    int n;
    restart();
    cfg(1'b1, 32'he81, 32'h30003);
    cfg(1'b0, 32'hc83, 32'h30003);
    push(1'b1, 4'h8, 64'h0a);
    repeat (10) @(posedge core_clk);
    push(1'b1, 4'h8, 64'h0b);
    push(1'b1, 4'h8, 64'h0c);
    push(1'b0, 4'h8, 64'h0d);
    repeat (200) @(posedge core_clk);
    n = 0;
    foreach (i_fsb_node.sent[i]) begin
      if (i_fsb_node.sent[i][78:68] === 11'h00e) begin
        check(i_fsb_node.sent[i], fr(11'h00e, 4'h8, n ? 64'h0c : 64'h0a));
        n++;
      end else begin
        check(i_fsb_node.sent[i], fr(11'h00c, 4'h8, 64'h0d));
      end
    end
    check(n, 32'h2);
    check(i_fsb_node.sent.size() >= 5, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short; all scenarios need well under this many cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    restart();
    t_regs();
    t_rx();
    t_cyc();
    t_evt();
    t_flush();
    t_latest();
    wrap_up();
  end
endmodule
`default_nettype wire
